/* File: rt_tx_pkg.sv */
// Package: record layout, information word fields, register map, interrupt bits and sequencer states for the transmit record block
package rt_tx_pkg;
   // -----------------------------------------------------------------
   // Record layout, relative to the descriptor data pointer
   // -----------------------------------------------------------------
   localparam logic [15:0] REC_INFO_OFS = 16'h0000;
   localparam logic [15:0] REC_TTAG_OFS = 16'h0001;
   localparam logic [15:0] REC_DATA_OFS = 16'h0002;

   // -----------------------------------------------------------------
   // Information word bit positions
   // -----------------------------------------------------------------
   localparam int GAP_OR_BROADCAST_BIT  = 13;
   localparam int WTALLY_ERR_BIT        = 12;
   localparam int MSG_FAULT_BIT         = 10;
   localparam int BUSY_BIT              = 9;
   localparam int ILLEGAL_BIT           = 8;
   localparam int TERM_XFER_BIT         = 6;
   localparam int BUS_SEL_BIT           = 5;
   localparam int TALLY_LSB             = 0;
   localparam int TALLY_W               = 5;
   // Extended configuration bit that selects gap versus broadcast meaning
   localparam int EXT_BROADCAST_SEL_BIT = 3;

   // -----------------------------------------------------------------
   // Register map of the plain register port (word offsets)
   // -----------------------------------------------------------------
   localparam logic [3:0] REG_EXT_CFG   = 4'h0;
   localparam logic [3:0] REG_STATUS    = 4'h1;
   localparam logic [3:0] REG_IRQ_CLR   = 4'h2;
   localparam logic [3:0] REG_IRQ_EN    = 4'h3;
   localparam logic [3:0] REG_LAST_INFO = 4'h4;
   localparam logic [3:0] REG_LAST_BASE = 4'h5;
   localparam logic [3:0] REG_GLB_BUSY  = 4'h6;

   // Reset values
   localparam logic [15:0] EXT_CFG_RST  = 16'h0000;
   localparam logic [2:0]  IRQ_EN_RST   = 3'h0;

   // Interrupt status bits
   localparam int IRQ_DONE_BIT  = 0;
   localparam int IRQ_FAULT_BIT = 1;
   localparam int IRQ_BUSY_BIT  = 2;
   localparam int IRQ_W         = 3;

   // Record sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_INFO = 2'b01,
      ST_TTAG = 2'b10
   } rec_state_e;
endpackage : rt_tx_pkg

/* File: info_word_build.sv */
// Combinational builder for the transmit information word
`timescale 1ns/100ps
module info_word_build (
   // Message outcome
   input  wire logic       broadcast_mode_i,
   input  wire logic       gap_seen_i,
   input  wire logic       broadcast_i,
   input  wire logic       extra_words_i,
   input  wire logic       busy_i,
   input  wire logic       illegal_i,
   input  wire logic       t2t_ok_i,
   input  wire logic       bus_b_i,
   input  wire logic [4:0] tally_i,
   // Result
   output logic      [15:0] info_o
);
   // ---------------------------------------------------------------
   // Assemble the word; unused bits stay zero
   // ---------------------------------------------------------------
   logic flag13;
   always_comb begin
      flag13 = broadcast_mode_i ? broadcast_i : gap_seen_i;
      info_o = 16'h0000;
      info_o[rt_tx_pkg::GAP_OR_BROADCAST_BIT] = flag13;
      info_o[rt_tx_pkg::WTALLY_ERR_BIT] = extra_words_i;
      // Fault summarises only the error conditions, not the broadcast meaning
      info_o[rt_tx_pkg::MSG_FAULT_BIT]  = extra_words_i | (~broadcast_mode_i & gap_seen_i);
      info_o[rt_tx_pkg::BUSY_BIT]       = busy_i;
      info_o[rt_tx_pkg::ILLEGAL_BIT]    = illegal_i;
      info_o[rt_tx_pkg::TERM_XFER_BIT]  = t2t_ok_i & ~extra_words_i & ~gap_seen_i & ~busy_i;
      info_o[rt_tx_pkg::BUS_SEL_BIT]    = bus_b_i;
      info_o[rt_tx_pkg::TALLY_LSB +: rt_tx_pkg::TALLY_W] = tally_i;
   end
endmodule : info_word_build

/* File: irq_status.sv */
// Sticky interrupt status with enable, write-one clear and level output
`timescale 1ns/100ps
module irq_status #(
   parameter int W = 3
) (
   // Clock and reset
   input  wire logic         clock_i,
   input  wire logic         rst_b_i,
   // Events and software control
   input  wire logic [W-1:0] event_i,
   input  wire logic [W-1:0] clear_i,
   input  wire logic [W-1:0] enable_i,
   // Results
   output logic      [W-1:0] status_o,
   output logic              irq_o
);
   logic [W-1:0] status_reg;
   logic [W-1:0] status_next;
   logic         irq_reg;
   logic         irq_next;

   // Set wins over clear so an event in the clearing cycle is kept
   always_comb begin
      status_next = (status_reg & ~clear_i) | event_i;
      irq_next    = |(status_next & enable_i);
   end

   // Registers
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         status_reg <= '0;
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_reg    <= irq_next;
      end
   end

   assign status_o = status_reg;
   assign irq_o    = irq_reg;
endmodule : irq_status

/* File: rt_transmit_msg_record.sv */
// Remote terminal transmit subaddress record writer: RAM record layout, status word build, registers
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/100ps

// Function
// - The data pointer is the record base: info word at base, time tag at base+1, data from base+2.
// - Information and time-tag words are written only after the message has completed.
// - With the select bit clear, bit 13 flags a gap error after the transmit command word.
// - With the select bit set, bit 13 flags that the message was broadcast.
// - Bit 12 flags a word count error when unexpected data words arrive with the command.
// - Bit 10 flags a message error whenever a bit 12 or bit 13 error occurred.
// - Bit 9 flags a busy answer, from global busy or the command's force-busy bit, and no data is sent.
// - Bit 8 flags that the illegalization entry for the command was one.
// - Bit 6 flags an error-free terminal-to-terminal transfer.
// - Bit 5 is zero for bus A and one for bus B.
// - Bits 4 to 0 carry the command word count, zero meaning 32.
module rt_transmit_msg_record #(
   parameter int AW = 16
) (
   // Clock and reset
   input  wire logic          clock_i,
   input  wire logic          rst_b_i,
   // Message from the protocol engine
   input  wire logic          cmd_start_i,
   input  wire logic [AW-1:0] data_pointer_i,
   input  wire logic [4:0]    command_word_tally_i,
   input  wire logic          command_force_busy_i,
   input  wire logic          illegal_entry_i,
   input  wire logic          bus_b_i,
   input  wire logic          broadcast_i,
   input  wire logic          gap_seen_i,
   input  wire logic          extra_words_i,
   input  wire logic          t2t_ok_i,
   input  wire logic          msg_done_i,
   input  wire logic [15:0]   time_tag_i,
   // Data word fetch for the transmitter
   input  wire logic          data_req_i,
   input  wire logic [4:0]    data_index_i,
   output logic               data_rd_o,
   output logic    [AW-1:0]   data_addr_o,
   output logic               send_inhibit_o,
   // Shared RAM write port
   output logic               ram_we_o,
   output logic    [AW-1:0]   ram_addr_o,
   output logic    [15:0]     ram_wdata_o,
   // Register port
   input  wire logic [3:0]    reg_addr_i,
   input  wire logic [15:0]   reg_wdata_i,
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   output logic    [15:0]     reg_rdata_o,
   // Interrupt
   output logic               irq_o
);
   if (AW < 3 || AW > 16) begin : g_aw_check
      $error("AW must lie between 3 and 16");
   end

   // ---------------------------------------------------------------
   // Address arithmetic
   // ---------------------------------------------------------------
   function automatic logic [AW-1:0] rec_addr(input logic [AW-1:0] base, input logic [15:0] ofs);
      rec_addr = base + ofs[AW-1:0];
   endfunction : rec_addr

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   rt_tx_pkg::rec_state_e state_reg, state_next;
   logic [AW-1:0] base_reg, base_next;
   logic [4:0]    tally_reg, tally_next;
   logic          busy_reg, busy_next;
   logic          ill_reg, ill_next;
   logic          bus_reg, bus_next;
   logic [15:0]   info_reg, info_next;
   logic [15:0]   ttag_reg, ttag_next;
   logic          we_reg, we_next;
   logic [AW-1:0] waddr_reg, waddr_next;
   logic [15:0]   wdata_reg, wdata_next;
   logic          drd_reg, drd_next;
   logic [AW-1:0] daddr_reg, daddr_next;
   logic          inh_reg, inh_next;
   logic [15:0]   last_info_reg, last_info_next;
   logic [AW-1:0] last_base_reg, last_base_next;
   logic [2:0]    evt_next;
   logic [2:0]    evt_reg;

   // Registers written by software, then read data, status and info word signals
   logic [15:0] ext_cfg_reg, ext_cfg_next;
   logic        glb_busy_reg, glb_busy_next;
   logic [2:0]  irq_en_reg, irq_en_next;
   logic [2:0]  irq_clr;
   logic [15:0] rdata_reg, rdata_next;
   logic [2:0]  irq_stat;
   logic [15:0] built_info;
   logic        busy_now;

   assign busy_now = glb_busy_reg | command_force_busy_i;

   info_word_build u_build (
      .broadcast_mode_i (ext_cfg_reg[rt_tx_pkg::EXT_BROADCAST_SEL_BIT]),
      .gap_seen_i    (gap_seen_i),
      .broadcast_i   (broadcast_i),
      .extra_words_i (extra_words_i),
      .busy_i        (busy_reg),
      .illegal_i     (ill_reg),
      .t2t_ok_i      (t2t_ok_i),
      .bus_b_i       (bus_reg),
      .tally_i       (tally_reg),
      .info_o        (built_info)
   );

   // ---------------------------------------------------------------
   // Record sequencer: latch the command, write info then time tag
   // ---------------------------------------------------------------
   always_comb begin
      state_next     = state_reg;
      base_next      = base_reg;
      tally_next     = tally_reg;
      busy_next      = busy_reg;
      ill_next       = ill_reg;
      bus_next       = bus_reg;
      info_next      = info_reg;
      ttag_next      = ttag_reg;
      we_next        = 1'b0;
      waddr_next     = waddr_reg;
      wdata_next     = wdata_reg;
      last_info_next = last_info_reg;
      last_base_next = last_base_reg;
      evt_next       = 3'h0;
      case (state_reg)
         rt_tx_pkg::ST_IDLE: begin
            if (cmd_start_i) begin
               base_next  = data_pointer_i;
               tally_next = command_word_tally_i;
               busy_next  = busy_now;
               ill_next   = illegal_entry_i;
               bus_next   = bus_b_i;
            end else if (msg_done_i) begin
               // Nothing goes to RAM until the message is over
               info_next  = built_info;
               ttag_next  = time_tag_i;
               we_next    = 1'b1;
               waddr_next = rec_addr(base_reg, rt_tx_pkg::REC_INFO_OFS);
               wdata_next = built_info;
               state_next = rt_tx_pkg::ST_INFO;
            end
         end
         rt_tx_pkg::ST_INFO: begin
            we_next    = 1'b1;
            waddr_next = rec_addr(base_reg, rt_tx_pkg::REC_TTAG_OFS);
            wdata_next = ttag_reg;
            state_next = rt_tx_pkg::ST_TTAG;
         end
         rt_tx_pkg::ST_TTAG: begin
            last_info_next = info_reg;
            last_base_next = base_reg;
            evt_next[rt_tx_pkg::IRQ_DONE_BIT]  = 1'b1;
            evt_next[rt_tx_pkg::IRQ_FAULT_BIT] = info_reg[rt_tx_pkg::MSG_FAULT_BIT];
            evt_next[rt_tx_pkg::IRQ_BUSY_BIT]  = info_reg[rt_tx_pkg::BUSY_BIT];
            state_next = rt_tx_pkg::ST_IDLE;
         end
         default: state_next = rt_tx_pkg::ST_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // Data fetch: data words begin two words past the base
   // ---------------------------------------------------------------
   always_comb begin
      // Busy answer sends no data words at all
      inh_next   = busy_reg;
      drd_next   = data_req_i & ~busy_reg;
      daddr_next = rec_addr(base_reg, rt_tx_pkg::REC_DATA_OFS + {11'h000, data_index_i});
   end

   // ---------------------------------------------------------------
   // Register port: decode writes and reads
   // ---------------------------------------------------------------
   always_comb begin
      ext_cfg_next  = ext_cfg_reg;
      glb_busy_next = glb_busy_reg;
      irq_en_next   = irq_en_reg;
      irq_clr       = 3'h0;
      rdata_next    = 16'h0000;
      if (reg_wr_i) begin
         if (reg_addr_i == rt_tx_pkg::REG_EXT_CFG) begin
            ext_cfg_next = reg_wdata_i;
         end else if (reg_addr_i == rt_tx_pkg::REG_IRQ_CLR) begin
            irq_clr = reg_wdata_i[2:0];
         end else if (reg_addr_i == rt_tx_pkg::REG_IRQ_EN) begin
            irq_en_next = reg_wdata_i[2:0];
         end else if (reg_addr_i == rt_tx_pkg::REG_GLB_BUSY) begin
            glb_busy_next = reg_wdata_i[0];
         end
      end
      if (reg_rd_i) begin
         if (reg_addr_i == rt_tx_pkg::REG_EXT_CFG) begin
            rdata_next = ext_cfg_reg;
         end else if (reg_addr_i == rt_tx_pkg::REG_STATUS) begin
            rdata_next = {13'h0000, irq_stat};
         end else if (reg_addr_i == rt_tx_pkg::REG_IRQ_EN) begin
            rdata_next = {13'h0000, irq_en_reg};
         end else if (reg_addr_i == rt_tx_pkg::REG_LAST_INFO) begin
            rdata_next = last_info_reg;
         end else if (reg_addr_i == rt_tx_pkg::REG_LAST_BASE) begin
            rdata_next = 16'(last_base_reg);
         end else if (reg_addr_i == rt_tx_pkg::REG_GLB_BUSY) begin
            rdata_next = {15'h0000, glb_busy_reg};
         end
      end
   end

   irq_status #(.W(rt_tx_pkg::IRQ_W)) u_irq (
      .clock_i  (clock_i),
      .rst_b_i  (rst_b_i),
      .event_i  (evt_reg),
      .clear_i  (irq_clr),
      .enable_i (irq_en_reg),
      .status_o (irq_stat),
      .irq_o    (irq_o)
   );

   // ---------------------------------------------------------------
   // All registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         state_reg     <= rt_tx_pkg::ST_IDLE;
         base_reg      <= '0;
         tally_reg     <= 5'h00;
         busy_reg      <= 1'b0;
         ill_reg       <= 1'b0;
         bus_reg       <= 1'b0;
         info_reg      <= 16'h0000;
         ttag_reg      <= 16'h0000;
         we_reg        <= 1'b0;
         waddr_reg     <= '0;
         wdata_reg     <= 16'h0000;
         drd_reg       <= 1'b0;
         daddr_reg     <= '0;
         inh_reg       <= 1'b0;
         last_info_reg <= 16'h0000;
         last_base_reg <= '0;
         evt_reg       <= 3'h0;
         ext_cfg_reg   <= rt_tx_pkg::EXT_CFG_RST;
         glb_busy_reg  <= 1'b0;
         irq_en_reg    <= rt_tx_pkg::IRQ_EN_RST;
         rdata_reg     <= 16'h0000;
      end else begin
         state_reg     <= state_next;
         base_reg      <= base_next;
         tally_reg     <= tally_next;
         busy_reg      <= busy_next;
         ill_reg       <= ill_next;
         bus_reg       <= bus_next;
         info_reg      <= info_next;
         ttag_reg      <= ttag_next;
         we_reg        <= we_next;
         waddr_reg     <= waddr_next;
         wdata_reg     <= wdata_next;
         drd_reg       <= drd_next;
         daddr_reg     <= daddr_next;
         inh_reg       <= inh_next;
         last_info_reg <= last_info_next;
         last_base_reg <= last_base_next;
         evt_reg       <= evt_next;
         ext_cfg_reg   <= ext_cfg_next;
         glb_busy_reg  <= glb_busy_next;
         irq_en_reg    <= irq_en_next;
         rdata_reg     <= rdata_next;
      end
   end

   assign ram_we_o       = we_reg;
   assign ram_addr_o     = waddr_reg;
   assign ram_wdata_o    = wdata_reg;
   assign data_rd_o      = drd_reg;
   assign data_addr_o    = daddr_reg;
   assign send_inhibit_o = inh_reg;
   assign reg_rdata_o    = rdata_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_info_write;
      ram_we_o && ram_addr_o == base_reg;
   endsequence
   sequence s_ttag_write;
      ram_we_o && ram_addr_o == rec_addr(base_reg, rt_tx_pkg::REC_TTAG_OFS);
   endsequence

   a_record_order: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (state_reg == rt_tx_pkg::ST_IDLE && msg_done_i && !cmd_start_i) |=> s_info_write ##1 s_ttag_write)
      else $error("record words not written at base then base+1");
   a_write_after_done: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      $rose(ram_we_o) |-> $past(msg_done_i))
      else $error("record written before message completion");
   a_tally_copy: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_info_write |-> ram_wdata_o[4:0] == tally_reg)
      else $error("word tally not copied");
   a_unused_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_info_write |-> ram_wdata_o[15:14] == 2'b00 && !ram_wdata_o[11] && !ram_wdata_o[7])
      else $error("unused info bits not zero");
   a_busy_no_data: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      busy_reg && data_req_i |=> !data_rd_o && send_inhibit_o)
      else $error("data fetched during busy answer");
   a_fault_cause: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_info_write |-> ram_wdata_o[10] == (ram_wdata_o[12] || (ram_wdata_o[13] && !ext_cfg_reg[3])))
      else $error("message fault mismatch");
   a_wc_error: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (state_reg == rt_tx_pkg::ST_IDLE && msg_done_i && !cmd_start_i && extra_words_i) |=> ram_wdata_o[12])
      else $error("word count error missing");
   a_bit13_meaning: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (state_reg == rt_tx_pkg::ST_IDLE && msg_done_i && !cmd_start_i)
      |=> ram_wdata_o[13] == ($past(ext_cfg_reg[3]) ? $past(broadcast_i) : $past(gap_seen_i)))
      else $error("bit 13 meaning wrong");
   a_data_addr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      data_req_i && !busy_reg
      |=> data_addr_o == $past(base_reg) + rt_tx_pkg::REC_DATA_OFS + {11'h000, $past(data_index_i)})
      else $error("data address not base plus two");
   a_bus_and_ill: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_info_write |-> ram_wdata_o[5] == bus_reg && ram_wdata_o[8] == ill_reg && ram_wdata_o[9] == busy_reg)
      else $error("bus, illegal or busy bit wrong");
endmodule : rt_transmit_msg_record

/* File: ram_host_model.sv */
// Host side of the shared RAM: prepares transmit records and serves data word fetches
`timescale 1ns/100ps
module ram_host_model (
   // Clock
   input  wire logic        clock_i,
   // Record writes from the terminal
   input  wire logic        ram_we_i,
   input  wire logic [15:0] ram_addr_i,
   input  wire logic [15:0] ram_wdata_i,
   // Data word fetch
   input  wire logic        data_rd_i,
   input  wire logic [15:0] data_addr_i,
   output logic      [15:0] data_o,
   output logic             bad_fetch_o
);
   // Only the low ten address bits are kept, enough for the records used
   logic [15:0]   mem [0:1023];
   logic [1023:0] filled;

   initial begin
      filled      = '0;
      bad_fetch_o = 1'b0;
      data_o      = 16'h0000;
   end

   // Host stores the data words and leaves the first two words as a marker
   task automatic fill(input logic [15:0] base, input int n);
      logic [9:0] a;
      a = base[9:0];
      mem[a]         = 16'hdead;
      mem[a + 10'h1] = 16'hdead;
      for (int k = 0; k < n; k++) begin
         mem[a + 10'h2 + k[9:0]]    = ~k[15:0];
         filled[a + 10'h2 + k[9:0]] = 1'b1;
      end
   endtask : fill

   function automatic logic [15:0] peek(input logic [15:0] a);
      return mem[a[9:0]];
   endfunction : peek

   // Fetch data changes every idle cycle so a stale value is never mistaken for a fresh one
   always @(posedge clock_i) begin
      if (ram_we_i) begin
         mem[ram_addr_i[9:0]] <= ram_wdata_i;
      end
      if (data_rd_i) begin
         data_o <= mem[data_addr_i[9:0]];
         if (!filled[data_addr_i[9:0]]) begin
            bad_fetch_o <= 1'b1;
         end
      end else begin
         data_o <= ~data_o;
      end
   end
endmodule : ram_host_model

/* File: tb_rt_transmit_msg_record.sv */
// Self-checking bench for the transmit record writer
`timescale 1ns/100ps
module tb_rt_transmit_msg_record;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic clock_i = 0, rst_b_i = 0, cmd_start_i = 0, command_force_busy_i = 0, illegal_entry_i = 0;
   logic bus_b_i = 0, broadcast_i = 0, gap_seen_i = 0, extra_words_i = 0, t2t_ok_i = 0;
   logic msg_done_i = 0, data_req_i = 0, reg_wr_i = 0, reg_rd_i = 0;
   logic [15:0] data_pointer_i = 0, time_tag_i = 0, reg_wdata_i = 0, rd_v;
   logic [4:0]  command_word_tally_i = 0, data_index_i = 0;
   logic [3:0]  reg_addr_i = 0;
   logic        data_rd_o, send_inhibit_o, ram_we_o, irq_o, sel_v = 0, gb_v = 0;
   logic [15:0] data_addr_o, ram_addr_o, ram_wdata_o, reg_rdata_o, fetch_data;
   int          error_cnt = 0, tests_run = 0, cyc = 0;

   always #50 clock_i = ~clock_i;

   rt_transmit_msg_record #(.AW(16)) i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cmd_start_i(cmd_start_i),
      .data_pointer_i(data_pointer_i), .command_word_tally_i(command_word_tally_i),
      .command_force_busy_i(command_force_busy_i), .illegal_entry_i(illegal_entry_i), .bus_b_i(bus_b_i),
      .broadcast_i(broadcast_i), .gap_seen_i(gap_seen_i), .extra_words_i(extra_words_i), .t2t_ok_i(t2t_ok_i),
      .msg_done_i(msg_done_i), .time_tag_i(time_tag_i), .data_req_i(data_req_i), .data_index_i(data_index_i),
      .data_rd_o(data_rd_o), .data_addr_o(data_addr_o), .send_inhibit_o(send_inhibit_o), .ram_we_o(ram_we_o),
      .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

   ram_host_model i_ram (.clock_i(clock_i), .ram_we_i(ram_we_o), .ram_addr_i(ram_addr_o),
      .ram_wdata_i(ram_wdata_o), .data_rd_i(data_rd_o), .data_addr_i(data_addr_o), .data_o(fetch_data),
      .bad_fetch_o());

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic end_of_test;
      $display("errors %0d compares %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask : reg_write

   // Read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask : reg_read

   // Flag bits: 0 force busy, 1 illegal, 2 bus B, 3 broadcast, 4 gap, 5 extra words, 6 t2t ok
   function automatic logic [15:0] exp_info(input logic [4:0] t, input logic [7:0] f);
      logic [15:0] w;
      w = 16'h0000;
      w[13] = sel_v ? f[3] : f[4];
      w[12] = f[5];
      w[10] = f[5] | (f[4] & !sel_v);
      w[9] = f[0] | gb_v;
      w[8] = f[1];
      w[6] = f[6] & !w[10] & !w[9];
      w[5] = f[2];
      w[4:0] = t;
      return w;
   endfunction : exp_info

   // One transmit message: command, a fetch of the last data word, completion, record check
   task automatic run_msg(input logic [15:0] base, input logic [4:0] t, input logic [7:0] f);
      logic [15:0] e;
      logic        b;
      e = exp_info(t, f);
      b = f[0] | gb_v;
      i_ram.fill(base, (t == 5'h00) ? 32 : int'(t));
      @(posedge clock_i);
      cmd_start_i <= 1'b1;
      data_pointer_i <= base;
      command_word_tally_i <= t;
      command_force_busy_i <= f[0];
      illegal_entry_i <= f[1];
      bus_b_i <= f[2];
      @(posedge clock_i);
      cmd_start_i <= 1'b0;
      data_req_i <= 1'b1;
      data_index_i <= t - 5'h01;
      @(posedge clock_i);
      data_req_i <= 1'b0;
      #1 chk({15'h0000, data_rd_o}, {15'h0000, !b});
      if (!b) chk(data_addr_o, base + 16'h0002 + {11'h000, t - 5'h01});
      chk({15'h0000, send_inhibit_o}, {15'h0000, b});
      chk(i_ram.peek(base), 16'hdead);
      @(posedge clock_i);
      msg_done_i <= 1'b1;
      broadcast_i <= f[3];
      gap_seen_i <= f[4];
      extra_words_i <= f[5];
      t2t_ok_i <= f[6];
      time_tag_i <= ~base;
      // Fetched word stands only in this cycle before the model scrambles it
      #1 if (!b) chk(fetch_data, ~{11'h000, t - 5'h01});
      @(posedge clock_i);
      msg_done_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      #1 chk(i_ram.peek(base), e);
      chk(i_ram.peek(base + 16'h0001), ~base);
      chk({15'h0000, i_ram.bad_fetch_o}, 16'h0000);
      reg_read(rt_tx_pkg::REG_LAST_INFO, rd_v);
      chk(rd_v, e);
   endtask : run_msg

   // ----------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         $display("[ERR] %0t run did not finish", $time);
         end_of_test;
      end
   end

   initial begin
      repeat (16) @(posedge clock_i);
      rst_b_i <= 1'b1;
      reg_write(rt_tx_pkg::REG_IRQ_CLR, 16'h0007);
      run_msg(16'h1500, 5'h03, 8'h00);
      run_msg(16'h1528, 5'h00, 8'h14);
      run_msg(16'h1550, 5'h1f, 8'h20);
      run_msg(16'h1578, 5'h02, 8'h42);
      run_msg(16'h15a0, 5'h02, 8'h60);
      run_msg(16'h15c8, 5'h04, 8'h01);
      gb_v = 1'b1;
      reg_write(rt_tx_pkg::REG_GLB_BUSY, 16'h0001);
      run_msg(16'h15f0, 5'h05, 8'h00);
      gb_v = 1'b0;
      reg_write(rt_tx_pkg::REG_GLB_BUSY, 16'h0000);
      sel_v = 1'b1;
      reg_write(rt_tx_pkg::REG_EXT_CFG, 16'h0008);
      run_msg(16'h1618, 5'h06, 8'h18);
      run_msg(16'h1640, 5'h06, 8'h10);
      sel_v = 1'b0;
      reg_write(rt_tx_pkg::REG_EXT_CFG, 16'h0000);
      // Sticky events stay up while masked; enabling done alone raises the line
      reg_read(rt_tx_pkg::REG_STATUS, rd_v);
      chk(rd_v, 16'h0007);
      chk({15'h0000, irq_o}, 16'h0000);
      reg_write(rt_tx_pkg::REG_IRQ_EN, 16'h0001);
      repeat (2) @(posedge clock_i);
      #1 chk({15'h0000, irq_o}, 16'h0001);
      reg_write(rt_tx_pkg::REG_IRQ_CLR, 16'h0001);
      reg_read(rt_tx_pkg::REG_STATUS, rd_v);
      chk(rd_v, 16'h0006);
      chk({15'h0000, irq_o}, 16'h0000);
      reg_read(rt_tx_pkg::REG_LAST_BASE, rd_v);
      chk(rd_v, 16'h1640);
      reg_read(4'hf, rd_v);
      chk(rd_v, 16'h0000);
      end_of_test;
   end
endmodule : tb_rt_transmit_msg_record
